// ### verilog/cpm_clock_power_ctrl.sv
/* clock and power-mode control: registers, protection, wait/stop and
   peripheral clock gate. assumes stability flags and a fetch strobe. */
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// What the document requires
// (RULE_01) Software starts sub oscillator: select off, drive high, enable, drive low.
// (RULE_02) After start-up completes, sub clock may be CPU clock or timer source.
// (RULE_03) Software changes the main divider only with no wait state selected.
// (RULE_04) Software never stops main clock while external clock drives the CPU.
// (RULE_05) External main clock source keeps running while it is the CPU clock.
// (RULE_06) Before wait with peripheral stop, divided CPU clock is at most 10 MHz.
// (RULE_07) Wait entry prefetches four queued instructions then halts; software pads nops.
// (RULE_08) Software executes wait only while the non-maskable interrupt pin is high.
// (RULE_09) Stop mode is refused while the non-maskable interrupt pin is low.
// (RULE_10) Reset leaving stop is held until the main oscillator is stable; this block has no such hold, stop ends on wake_irq.
// (RULE_11) Using the interrupt wake, software takes a dummy interrupt before stopping.
// (RULE_12) Stop entry queues instructions; queued one runs on exit before handler.
// (RULE_13) Peripheral-stop-in-wait halts peripheral clock in wait; div32 keeps running.
// (RULE_14) From low-speed mode software leaves peripheral-stop-in-wait cleared.
// (RULE_15) Unlock bit clears itself on the next write to any register address.
// (RULE_16) Software writes the protected register right after setting the unlock bit.
// (RULE_17) Software waits for a stable clock before switching the CPU clock to it.
// (RULE_18) For fast CPU clocks, feed at most 24 MHz and multiply with the PLL.
module cpm_clock_power_ctrl
    import cpm_pkg::*;
#(
    parameter int QUEUE_DEPTH = CPM_QUEUE_DEPTH
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 clk_en,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 nonmaskable_int_pin,
    input  wire logic                 sub_osc_stable,
    input  wire logic                 wake_irq,
    input  wire logic                 queue_fetch,
    output logic                      sub_osc_enable,
    output logic                      sub_osc_drive_high,
    output logic                      main_clock_stop,
    output logic                      cpu_clock_sub_sel,
    output logic                      timer_sub_source_ok,
    output logic [CPM_DIV_W-1:0]      main_clock_divider,
    output logic                      wait_state_select,
    output logic                      periph_clock_run,
    output logic                      sub_clock_div32_run,
    output logic                      cpu_halt,
    output logic                      run_queued
);
    import cpm_pkg::*;

    logic        wr_stb, wr_err, rd_err;
    logic [7:0]  wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0]  wr_strb;

    cpm_axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .clk_en        (clk_en),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_stb        (wr_stb),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    logic [7:0]           clock_control_reg_0, next_ctrl0;
    logic [7:0]           clock_control_reg_1, next_ctrl1;
    logic [CPM_DIV_W-1:0] main_divider_reg, next_div;
    logic [7:0]           processor_mode_reg_1, next_pm1;
    logic                 protect_unlock_2, next_unlock;
    logic                 sub_ready, next_sub_ready;
    cpm_mode_e            mode, next_mode;
    cpm_mode_e            queue_target, next_queue_target;
    logic [2:0]           queue_cnt, next_queue_cnt;
    logic                 next_halt, next_run_queued, next_pclk_run;
    logic                 wr0, wr1, wr_div, wr_pm1, wr_prot, wr_cmd;
    logic                 stop_req, wait_req;

    assign wr0    = wr_stb & wr_strb[0] & (wr_addr == CPM_CLK_CTRL0_OFS);
    assign wr1    = wr_stb & wr_strb[0] & (wr_addr == CPM_CLK_CTRL1_OFS);
    assign wr_div = wr_stb & wr_strb[0] & (wr_addr == CPM_DIVIDER_OFS);
    assign wr_pm1 = wr_stb & wr_strb[0] & (wr_addr == CPM_PROC_MODE1_OFS);
    assign wr_prot = wr_stb & wr_strb[0] & (wr_addr == CPM_PROTECT_OFS);
    assign wr_cmd = wr_stb & wr_strb[0] & (wr_addr == CPM_POWER_CMD_OFS);
    assign wr_err = ~(wr_addr inside {CPM_CLK_CTRL0_OFS, CPM_CLK_CTRL1_OFS,
                      CPM_DIVIDER_OFS, CPM_PROC_MODE1_OFS, CPM_PROTECT_OFS,
                      CPM_POWER_CMD_OFS, CPM_STATUS_OFS});

    // stop needs the interrupt pin high [RULE_09]
    assign stop_req = wr1 & protect_unlock_2 & wr_data[CPM_C1_ALL_STOP]
                      & nonmaskable_int_pin;
    assign wait_req = wr_cmd & wr_data[CPM_CMD_WAIT];

    always_comb begin
        next_ctrl0  = clock_control_reg_0;
        next_ctrl1  = clock_control_reg_1;
        next_div    = main_divider_reg;
        next_pm1    = processor_mode_reg_1;
        next_unlock = protect_unlock_2;
        // any register write ends the unlock window [RULE_15]
        if (wr_stb)
            next_unlock = 1'b0;
        if (wr_prot)
            next_unlock = wr_data[CPM_PROT_UNLOCK2];
        if (wr0 & protect_unlock_2)
            next_ctrl0 = wr_data[7:0];
        // sub clock as CPU clock only once start-up is done [RULE_02]
        if (wr0 & protect_unlock_2 & ~sub_ready)
            next_ctrl0[CPM_C0_SUB_CPU_SEL] = 1'b0;
        if (wr1 & protect_unlock_2)
            next_ctrl1 = wr_data[7:0] & ~8'h01;
        // divider frozen while a wait state is inserted
        if (wr_div & ~processor_mode_reg_1[CPM_PM1_WAIT_STATE])
            next_div = wr_data[CPM_DIV_W-1:0];
        if (wr_pm1)
            next_pm1 = wr_data[7:0];
        // oscillator loss drops readiness; enable, stable and drive low together set it
        next_sub_ready = clock_control_reg_0[CPM_C0_SUB_OSC_EN]
                         & sub_osc_stable
                         & ~clock_control_reg_0[CPM_C0_SUB_DRIVE_HIGH];
    end

    always_comb begin
        next_mode         = mode;
        next_queue_target = queue_target;
        next_queue_cnt    = queue_cnt;
        next_run_queued   = 1'b0;
        unique case (mode)
            CPM_RUN: begin
                if (stop_req | wait_req) begin
                    next_mode         = CPM_QUEUE;
                    next_queue_target = stop_req ? CPM_STOP : CPM_WAIT;
                    next_queue_cnt    = 3'd0;
                end
            end
            CPM_QUEUE: begin
                // fill the queue before halting [RULE_07] [RULE_12]
                if (queue_fetch)
                    next_queue_cnt = queue_cnt + 3'd1;
                if (queue_fetch
                    && queue_cnt == 3'(QUEUE_DEPTH - 1))
                    next_mode = queue_target;
            end
            CPM_WAIT, CPM_STOP: begin
                // queued instruction runs before the wake handler [RULE_12]
                if (wake_irq) begin
                    next_mode       = CPM_RUN;
                    next_run_queued = 1'b1;
                end
            end
        endcase
        next_halt = (next_mode == CPM_WAIT) | (next_mode == CPM_STOP);
        // peripheral clock halts in wait only when asked [RULE_13]
        next_pclk_run = ~(next_mode == CPM_STOP)
            & ~((next_mode == CPM_WAIT)
                & clock_control_reg_0[CPM_C0_PCLK_STOP_WAIT]);
    end

    always_comb begin
        rd_err  = 1'b0;
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            CPM_CLK_CTRL0_OFS:  rd_data[7:0] = clock_control_reg_0;
            CPM_CLK_CTRL1_OFS:  rd_data[7:0] = clock_control_reg_1;
            CPM_DIVIDER_OFS:    rd_data[CPM_DIV_W-1:0] = main_divider_reg;
            CPM_PROC_MODE1_OFS: rd_data[7:0] = processor_mode_reg_1;
            CPM_PROTECT_OFS:    rd_data[CPM_PROT_UNLOCK2] = protect_unlock_2;
            CPM_POWER_CMD_OFS:  rd_data = 32'h0000_0000;
            CPM_STATUS_OFS: begin
                rd_data[CPM_ST_SUB_READY]    = sub_ready;
                rd_data[CPM_ST_WAIT]         = (mode == CPM_WAIT);
                rd_data[CPM_ST_STOP]         = (mode == CPM_STOP);
                rd_data[CPM_ST_PCLK_RUN]     = periph_clock_run;
                rd_data[CPM_ST_QUEUE_LO+2:CPM_ST_QUEUE_LO] = queue_cnt;
                rd_data[CPM_ST_SUB_SELECTED] = cpu_clock_sub_sel;
            end
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_control_reg_0  <= CPM_C0_RESET;
            clock_control_reg_1  <= CPM_C1_RESET;
            main_divider_reg     <= CPM_DIV_RESET;
            processor_mode_reg_1 <= CPM_PM1_RESET;
            protect_unlock_2     <= 1'b0;
            sub_ready            <= 1'b0;
            mode                 <= CPM_RUN;
            queue_target         <= CPM_WAIT;
            queue_cnt            <= 3'd0;
            cpu_halt             <= 1'b0;
            run_queued           <= 1'b0;
            periph_clock_run     <= 1'b1;
            sub_osc_enable       <= 1'b0;
            sub_osc_drive_high   <= 1'b1;
            main_clock_stop      <= 1'b0;
            cpu_clock_sub_sel    <= 1'b0;
            timer_sub_source_ok  <= 1'b0;
            main_clock_divider   <= CPM_DIV_RESET;
            wait_state_select    <= 1'b0;
            sub_clock_div32_run  <= 1'b0;
        end else if (clk_en) begin
            clock_control_reg_0  <= next_ctrl0;
            clock_control_reg_1  <= next_ctrl1;
            main_divider_reg     <= next_div;
            processor_mode_reg_1 <= next_pm1;
            protect_unlock_2     <= next_unlock;
            sub_ready            <= next_sub_ready;
            mode                 <= next_mode;
            queue_target         <= next_queue_target;
            queue_cnt            <= next_queue_cnt;
            cpu_halt             <= next_halt;
            run_queued           <= next_run_queued;
            periph_clock_run     <= next_pclk_run; // [RULE_13]
            sub_osc_enable       <= next_ctrl0[CPM_C0_SUB_OSC_EN];
            sub_osc_drive_high   <= next_ctrl0[CPM_C0_SUB_DRIVE_HIGH];
            main_clock_stop      <= next_ctrl0[CPM_C0_MAIN_STOP];
            cpu_clock_sub_sel    <= next_ctrl0[CPM_C0_SUB_CPU_SEL];
            timer_sub_source_ok  <= next_sub_ready; // [RULE_02]
            main_clock_divider   <= next_div;
            wait_state_select    <= next_pm1[CPM_PM1_WAIT_STATE];
            // div32 ignores the wait-mode peripheral gate [RULE_13]
            sub_clock_div32_run  <= next_sub_ready & (next_mode != CPM_STOP);
        end
    end
endmodule : cpm_clock_power_ctrl

// ### include/cpm_pkg.sv
/* constants of the clock and power-mode block: offsets, fields, resets.
   assumes one aligned 32-bit word per register. */
package cpm_pkg;
    localparam int unsigned CPM_CLK_HZ = 20_000_000;

    // register byte addresses
    localparam logic [7:0] CPM_CLK_CTRL0_OFS  = 8'h00;
    localparam logic [7:0] CPM_CLK_CTRL1_OFS  = 8'h04;
    localparam logic [7:0] CPM_DIVIDER_OFS    = 8'h08;
    localparam logic [7:0] CPM_PROC_MODE1_OFS = 8'h0c;
    localparam logic [7:0] CPM_PROTECT_OFS    = 8'h10;
    localparam logic [7:0] CPM_POWER_CMD_OFS  = 8'h14;
    localparam logic [7:0] CPM_STATUS_OFS     = 8'h18;

    // clock_control_reg_0 fields
    localparam int CPM_C0_PCLK_STOP_WAIT = 2;
    localparam int CPM_C0_SUB_DRIVE_HIGH = 3;
    localparam int CPM_C0_SUB_OSC_EN     = 4;
    localparam int CPM_C0_MAIN_STOP      = 5;
    localparam int CPM_C0_SUB_CPU_SEL    = 7;
    localparam logic [7:0] CPM_C0_RESET  = 8'h08;
    // clock_control_reg_1 fields
    localparam int CPM_C1_ALL_STOP       = 0;
    localparam logic [7:0] CPM_C1_RESET  = 8'h00;
    // main_divider_reg
    localparam int CPM_DIV_W             = 5;
    localparam logic [4:0] CPM_DIV_RESET = 5'h08;
    // processor_mode_reg_1
    localparam int CPM_PM1_WAIT_STATE    = 2;
    localparam logic [7:0] CPM_PM1_RESET = 8'h00;
    // protection register
    localparam int CPM_PROT_UNLOCK2      = 2;
    // power command register
    localparam int CPM_CMD_WAIT          = 0;
    localparam int CPM_CMD_WAKE          = 1;
    // status fields
    localparam int CPM_ST_SUB_READY      = 0;
    localparam int CPM_ST_WAIT           = 1;
    localparam int CPM_ST_STOP           = 2;
    localparam int CPM_ST_PCLK_RUN       = 3;
    localparam int CPM_ST_QUEUE_LO       = 4;
    localparam int CPM_ST_SUB_SELECTED   = 7;

    // instructions prefetched into the queue on wait/stop entry
    localparam int unsigned CPM_QUEUE_DEPTH = 4;

    localparam logic [1:0] CPM_RESP_OKAY   = 2'b00;
    localparam logic [1:0] CPM_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CPM_RUN,
        CPM_QUEUE,
        CPM_WAIT,
        CPM_STOP
    } cpm_mode_e;
endpackage : cpm_pkg

// ### verilog/cpm_axil_slave.sv
/* AXI4-Lite front end: one read at a time, a new write can be taken in the strobe cycle before the last response, one-cycle
   write strobe. assumes read data combinational from rd_addr. */
`timescale 1ns/1ps
module cpm_axil_slave
    import cpm_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_stb,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    logic        aw_have, w_have, next_aw_have, next_w_have;
    logic        next_bvalid, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [7:0]  next_wr_addr, next_rd_addr;
    logic [31:0] next_wr_data;
    logic [3:0]  next_wr_strb;
    logic        next_wr_stb, aw_take, w_take;
    logic        rd_pend, next_rd_pend;

    assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have & ~s_axi_bvalid;
    assign s_axi_arready = ~rd_pend & ~s_axi_rvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;

    always_comb begin
        next_aw_have = aw_have | aw_take;
        next_w_have  = w_have | w_take;
        next_wr_addr = aw_take ? s_axi_awaddr : wr_addr;
        next_wr_data = w_take ? s_axi_wdata : wr_data;
        next_wr_strb = w_take ? s_axi_wstrb : wr_strb;
        next_wr_stb  = 1'b0;
        next_bvalid  = s_axi_bvalid & ~s_axi_bready;
        next_bresp   = s_axi_bresp;
        if (wr_stb) begin
            next_bvalid = 1'b1;
            next_bresp  = wr_err ? CPM_RESP_SLVERR : CPM_RESP_OKAY;
        end
        if (aw_have & w_have & ~wr_stb) begin
            next_wr_stb  = 1'b1;
            next_aw_have = 1'b0;
            next_w_have  = 1'b0;
        end
        next_rd_pend = rd_pend;
        next_rd_addr = rd_addr;
        next_rvalid  = s_axi_rvalid & ~s_axi_rready;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_arvalid & s_axi_arready) begin
            next_rd_pend = 1'b1;
            next_rd_addr = s_axi_araddr;
        end
        if (rd_pend) begin
            next_rd_pend = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = rd_data;
            next_rresp   = rd_err ? CPM_RESP_SLVERR : CPM_RESP_OKAY;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            wr_stb       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= CPM_RESP_OKAY;
            rd_pend      <= 1'b0;
            rd_addr      <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= CPM_RESP_OKAY;
        end else if (clk_en) begin
            aw_have      <= next_aw_have;
            w_have       <= next_w_have;
            wr_addr      <= next_wr_addr;
            wr_data      <= next_wr_data;
            wr_strb      <= next_wr_strb;
            wr_stb       <= next_wr_stb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            rd_pend      <= next_rd_pend;
            rd_addr      <= next_rd_addr;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end
endmodule : cpm_axil_slave

// ### test/cpm_osc_model.sv
/* sub crystal model: stable only after a start-up spent at high drive.
   assumes enable and drive come from the block on one clock. */
`timescale 1ns/1ps
module cpm_osc_model #(
    parameter int STARTUP = 24
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic osc_enable,
    input  wire logic osc_drive_high,
    output logic      osc_stable
);
    int cnt;
    // no build-up at low drive, so a bad start order never settles
    always_ff @(posedge aclk) begin
        if (!aresetn || !osc_enable)
            cnt <= 0;
        else if (cnt < STARTUP && osc_drive_high)
            cnt <= cnt + 1;
    end
    // once settled it runs on without a gap while enabled
    assign osc_stable = (cnt == STARTUP);
endmodule : cpm_osc_model

// ### test/cpm_chk.sv
/* port checker for the clock and power-mode block.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module cpm_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        queue_fetch,
    input wire logic        wake_irq,
    input wire logic        cpu_halt,
    input wire logic        run_queued,
    input wire logic        periph_clock_run,
    input wire logic [4:0]  main_clock_divider,
    input wire logic        wait_state_select,
    input wire logic        cpu_clock_sub_sel,
    input wire logic        sub_osc_enable,
    input wire logic        sub_osc_drive_high
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
    ) else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    ) else $error("read data dropped early");
    div_lock_a: assert property (
        $changed(main_clock_divider) |-> !$past(wait_state_select)
    ) else $error("divider changed with wait state on");
    sub_select_a: assert property (
        $rose(cpu_clock_sub_sel) |-> sub_osc_enable && !sub_osc_drive_high
    ) else $error("sub clock selected before start-up");
    halt_fetch_a: assert property (
        $rose(cpu_halt) |-> $past(queue_fetch) || $past(queue_fetch, 2)
    ) else $error("halt without queue fill");
    wake_end_a: assert property (
        $fell(cpu_halt) |-> $past(wake_irq) || $past(wake_irq, 2)
    ) else $error("halt ended without wake");
    queued_pulse_a: assert property (
        run_queued |=> !run_queued
    ) else $error("queued run longer than one cycle");
    pclk_gate_a: assert property (
        $fell(periph_clock_run) |-> ##[0:2] cpu_halt
    ) else $error("peripheral clock stopped while running");
endmodule : cpm_chk

bind cpm_clock_power_ctrl cpm_chk chk (.*);

// ### test/clock_power_mode_control_tb.sv
/* self-checking bench for the clock and power-mode block.
   assumes the crystal model in cpm_osc_model. */
`timescale 1ns/1ps
module clock_power_mode_control_tb;
    import cpm_pkg::*;
    logic aclk = 0, aresetn = 0, clk_en = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic nonmaskable_int_pin = 1, wake_irq = 0, queue_fetch = 0;
    logic sub_osc_stable, sub_osc_enable, sub_osc_drive_high;
    logic main_clock_stop, cpu_clock_sub_sel, timer_sub_source_ok;
    logic wait_state_select, periph_clock_run, sub_clock_div32_run;
    logic cpu_halt, run_queued;
    logic [CPM_DIV_W-1:0] main_clock_divider;
    int n_errors = 0, total_checks = 0;
    always #25 aclk = ~aclk;
    cpm_clock_power_ctrl dut (.*);
    cpm_osc_model osc (.aclk(aclk), .aresetn(aresetn),
        .osc_enable(sub_osc_enable), .osc_drive_high(sub_osc_drive_high),
        .osc_stable(sub_osc_stable));
    task chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        chk(nm, e, rd);
    endtask : rchk
    // nothing may come between unlock and guarded write
    task uw(input logic [7:0] a, input logic [31:0] d);
        wr(CPM_PROTECT_OFS, 32'h4);
        wr(a, d);
    endtask : uw
    task fetch(input int n);
        repeat (n) @(posedge aclk) queue_fetch <= 1'b1;
        @(posedge aclk) queue_fetch <= 1'b0;
    endtask : fetch
    task wake;
        @(posedge aclk) wake_irq <= 1'b1;
        @(posedge aclk) wake_irq <= 1'b0;
        while (cpu_halt !== 1'b0) @(posedge aclk);
    endtask : wake
    task t_reset;
        rchk("ctrl0", CPM_CLK_CTRL0_OFS, {24'h0, CPM_C0_RESET});
        rchk("divider", CPM_DIVIDER_OFS, {27'h0, CPM_DIV_RESET});
        rchk("unmapped", 8'h1c, 32'h0);
        chk("rresp", {30'h0, CPM_RESP_SLVERR}, {30'h0, rs});
        $display("t_reset done");
    endtask : t_reset
    task t_protect;
        wr(CPM_CLK_CTRL0_OFS, 32'h18);
        rchk("ctrl0 locked", CPM_CLK_CTRL0_OFS, 32'h08);
        wr(CPM_PROTECT_OFS, 32'h4);
        wr(CPM_DIVIDER_OFS, 32'h08);
        wr(CPM_CLK_CTRL0_OFS, 32'h18);
        rchk("ctrl0 relock", CPM_CLK_CTRL0_OFS, 32'h08);
        uw(CPM_CLK_CTRL0_OFS, 32'h18);
        rchk("ctrl0 open", CPM_CLK_CTRL0_OFS, 32'h18);
        $display("t_protect done");
    endtask : t_protect
    task t_sub;
        while (sub_osc_stable !== 1'b1) @(posedge aclk);
        uw(CPM_CLK_CTRL0_OFS, 32'h98);
        rchk("early select", CPM_CLK_CTRL0_OFS, 32'h18);
        uw(CPM_CLK_CTRL0_OFS, 32'h10);
        uw(CPM_CLK_CTRL0_OFS, 32'h90);
        rchk("select", CPM_CLK_CTRL0_OFS, 32'h90);
        chk("timer ok", 32'h1, {31'h0, timer_sub_source_ok});
        chk("cpu sub", 32'h1, {31'h0, cpu_clock_sub_sel});
        chk("main stop", 32'h0, {31'h0, main_clock_stop});
        $display("t_sub done");
    endtask : t_sub
    task t_div;
        wr(CPM_PROC_MODE1_OFS, 32'h4);
        wr(CPM_DIVIDER_OFS, 32'h02);
        rchk("div held", CPM_DIVIDER_OFS, 32'h08);
        wr(CPM_PROC_MODE1_OFS, 32'h0);
        wr(CPM_DIVIDER_OFS, 32'h02);
        rchk("div set", CPM_DIVIDER_OFS, 32'h02);
        $display("t_div done");
    endtask : t_div
    task t_stop;
        nonmaskable_int_pin <= 1'b0;
        uw(CPM_CLK_CTRL1_OFS, 32'h1);
        fetch(4);
        rchk("refused", CPM_STATUS_OFS, 32'h89);
        nonmaskable_int_pin <= 1'b1;
        uw(CPM_CLK_CTRL1_OFS, 32'h1);
        fetch(3);
        rchk("queue 3", CPM_STATUS_OFS, 32'hb9);
        fetch(1);
        while (cpu_halt !== 1'b1) @(posedge aclk);
        chk("stop pclk", 32'h0, {31'h0, periph_clock_run});
        wake();
        rchk("after stop", CPM_STATUS_OFS, 32'hc9);
        $display("t_stop done");
    endtask : t_stop
    task t_wait;
        uw(CPM_CLK_CTRL0_OFS, 32'h14);
        wr(CPM_POWER_CMD_OFS, 32'h1);
        fetch(4);
        while (cpu_halt !== 1'b1) @(posedge aclk);
        chk("wait pclk", 32'h0, {31'h0, periph_clock_run});
        chk("div32", 32'h1, {31'h0, sub_clock_div32_run});
        wake();
        rchk("after wait", CPM_STATUS_OFS, 32'h49);
        $display("t_wait done");
    endtask : t_wait
    task test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_protect();
        t_sub();
        t_div();
        t_stop();
        t_wait();
        test_done();
    end
    // the run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        test_done();
    end
endmodule : clock_power_mode_control_tb
